// ==== src/rbt_regs.svh ====
// Notes on behaviour
// - both ports are 18 bits; each direction control acts on all 18 bits together
// - a-to-b latch enable high makes storage transparent; b follows a regardless of clock
// - latch enable low with steady clock: storage holds, port a changes ignored
// - latch enable low: each a-to-b clock rising edge captures port a into storage
// - a-to-b output enable low floats port b; high drives stored a-to-b value
// - b-to-a path mirrors a-to-b with its own latch enable, clock, output enable
// - b-to-a output enable is active low: port a drives only while it is low
// - clock held high keeps output only if it was high before latch enable fell
// - each port pin is input for one direction, three-state output for the other
// - with bus hold on, an input released to high impedance keeps its last level
`ifndef RBT_REGS_SVH
`define RBT_REGS_SVH

`define RBT_WIDTH 18

`define RBT_OFS_CTRL 12'h000
`define RBT_OFS_STATUS 12'h004
`define RBT_OFS_A2B 12'h008
`define RBT_OFS_B2A 12'h00c

`define RBT_CTRL_HOLD_BIT 0
`define RBT_CTRL_RESET 1'h0

`define RBT_STAT_CONT_A_BIT 0
`define RBT_STAT_CONT_B_BIT 1
`define RBT_STAT_LIVE_LSB 2
`define RBT_STAT_LIVE_MSB 7

`define RBT_CLK_Q_RESET 1'h1
`define RBT_PRDATA_RESET 32'h00000000

`endif

// ==== src/rbt_pkg.sv ====
package rbt_pkg;

   typedef logic [17:0] rbt_data_t;

   // level seen on a data port plus whether the outside driver is active
   typedef struct packed {
      rbt_data_t data;
      logic drv;
   } rbt_pin_s;

endpackage : rbt_pkg

// ==== src/rbt_path.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rbt_regs.svh"

module rbt_path (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic hold_en,
   input wire rbt_pkg::rbt_pin_s src,
   input wire logic latch_en,
   input wire logic cap_clk,
   output var rbt_pkg::rbt_data_t stored
);

   rbt_pkg::rbt_data_t hold;
   rbt_pkg::rbt_data_t eff_in;
   logic clk_q;
   logic cap_rise;
   logic load;

   // bus hold keeper, follows the pin only while it is driven
   always_ff @(posedge pclk) begin
      if (src.drv) begin
         hold <= src.data;
      end
   end

   assign eff_in = (hold_en && !src.drv) ? hold : src.data;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_q <= `RBT_CLK_Q_RESET;
      end else begin
         clk_q <= cap_clk;
      end
   end

   // a clock already high when latch enable falls gives no edge
   assign cap_rise = cap_clk && !clk_q;
   assign load = latch_en || cap_rise;

   // storage has no reset
   always_ff @(posedge pclk) begin
      if (load) begin
         stored <= eff_in;
      end
   end

endmodule : rbt_path
`default_nettype wire

// ==== src/rbt_transceiver.sv ====
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rbt_regs.svh"

module rbt_transceiver (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output var logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic a_to_b_out_en,
   input wire logic a_to_b_latch_en,
   input wire logic a_to_b_clk,
   input wire logic b_to_a_out_en_n,
   input wire logic b_to_a_latch_en,
   input wire logic b_to_a_clk,
   input wire rbt_pkg::rbt_pin_s a_pin,
   output var rbt_pkg::rbt_data_t a_out,
   output logic [17:0] a_oe,
   input wire rbt_pkg::rbt_pin_s b_pin,
   output var rbt_pkg::rbt_data_t b_out,
   output logic [17:0] b_oe
);

   rbt_pkg::rbt_data_t a2b_stored;
   rbt_pkg::rbt_data_t b2a_stored;
   logic hold_en;
   logic cont_a;
   logic cont_b;
   logic next_cont_a;
   logic next_cont_b;
   logic slverr_q;

   // apb decode
   wire apb_setup = psel && !penable;
   wire apb_access = psel && penable;
   wire [11:0] word_addr = {paddr[11:2], 2'h0};
   wire hit_ctrl = (word_addr == `RBT_OFS_CTRL);
   wire hit_status = (word_addr == `RBT_OFS_STATUS);
   wire hit_a2b = (word_addr == `RBT_OFS_A2B);
   wire hit_b2a = (word_addr == `RBT_OFS_B2A);
   wire mapped = hit_ctrl || hit_status || hit_a2b || hit_b2a;
   wire wr_go = apb_access && pwrite && mapped && pstrb[0];
   wire wr_ctrl = wr_go && hit_ctrl;
   wire wr_status = wr_go && hit_status;

   wire [5:0] live_ctl = {b_to_a_clk, b_to_a_latch_en, b_to_a_out_en_n,
                          a_to_b_clk, a_to_b_latch_en, a_to_b_out_en};
   wire [31:0] rd_ctrl = {31'h00000000, hold_en};
   wire [31:0] rd_status = {24'h000000, live_ctl, cont_b, cont_a};
   wire [31:0] rd_a2b = {14'h0000, a2b_stored};
   wire [31:0] rd_b2a = {14'h0000, b2a_stored};
   wire [31:0] rd_mux = hit_ctrl ? rd_ctrl :
                        hit_status ? rd_status :
                        hit_a2b ? rd_a2b :
                        hit_b2a ? rd_b2a : 32'h00000000;

   // one setup cycle then a zero wait access phase
   assign pready = apb_access;
   assign pslverr = apb_access && slverr_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= `RBT_PRDATA_RESET;
         slverr_q <= 1'h0;
      end else if (apb_setup) begin
         prdata <= pwrite ? 32'h00000000 : rd_mux;
         slverr_q <= !mapped;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_en <= `RBT_CTRL_RESET;
      end else if (wr_ctrl) begin
         hold_en <= pwdata[`RBT_CTRL_HOLD_BIT];
      end
   end

   // contention flags, a new event wins over a write-one clear
   wire set_cont_a = a_pin.drv && !b_to_a_out_en_n;
   wire set_cont_b = b_pin.drv && a_to_b_out_en;
   wire clr_cont_a = wr_status && pwdata[`RBT_STAT_CONT_A_BIT];
   wire clr_cont_b = wr_status && pwdata[`RBT_STAT_CONT_B_BIT];

   assign next_cont_a = set_cont_a || (cont_a && !clr_cont_a);
   assign next_cont_b = set_cont_b || (cont_b && !clr_cont_b);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cont_a <= 1'h0;
         cont_b <= 1'h0;
      end else begin
         cont_a <= next_cont_a;
         cont_b <= next_cont_b;
      end
   end

   // two independent direction paths
   rbt_path u_a_to_b (
      .pclk(pclk),
      .presetn(presetn),
      .hold_en(hold_en),
      .src(a_pin),
      .latch_en(a_to_b_latch_en),
      .cap_clk(a_to_b_clk),
      .stored(a2b_stored)
   );

   rbt_path u_b_to_a (
      .pclk(pclk),
      .presetn(presetn),
      .hold_en(hold_en),
      .src(b_pin),
      .latch_en(b_to_a_latch_en),
      .cap_clk(b_to_a_clk),
      .stored(b2a_stored)
   );

   // pin drivers, each enable spans the whole port
   assign b_out = a2b_stored;
   assign a_out = b2a_stored;
   assign b_oe = {18{a_to_b_out_en}};
   assign a_oe = {18{!b_to_a_out_en_n}};

   // checks
   default clocking cb @(posedge pclk);
   endclocking

   default disable iff (!presetn);

   sequence s_a2b_rise;
      !a_to_b_clk ##1 (a_to_b_clk && !a_to_b_latch_en && a_pin.drv);
   endsequence

   sequence s_a2b_high_fall;
      (a_to_b_clk && a_to_b_latch_en) ##1 (a_to_b_clk && !a_to_b_latch_en) [*2];
   endsequence

   sequence s_a_release;
      (hold_en && a_pin.drv && a_to_b_latch_en)
         ##1 (hold_en && !a_pin.drv && a_to_b_latch_en);
   endsequence

   a_port_width_whole: assert property (
      (a_oe == 18'h00000 || a_oe == 18'h3ffff) && (b_oe == 18'h00000 || b_oe == 18'h3ffff))
      else $error("output enable split across port bits");

   a_a2b_transparent: assert property (
      (a_to_b_latch_en && a_pin.drv) |=> b_out == $past(a_pin.data))
      else $error("a-to-b path not transparent");

   a_a2b_hold_steady: assert property (
      (!a_to_b_latch_en && !$rose(a_to_b_clk)) |=> $stable(b_out))
      else $error("a-to-b storage changed while latched");

   a_a2b_edge_capture: assert property (
      s_a2b_rise |=> b_out == $past(a_pin.data))
      else $error("a-to-b clock edge did not capture port a");

   a_b_port_float: assert property (
      !a_to_b_out_en |-> b_oe == 18'h00000)
      else $error("port b not floated while output enable low");

   a_b_port_drive: assert property (
      a_to_b_out_en |-> b_oe == 18'h3ffff)
      else $error("port b not driven while output enable high");

   a_b2a_transparent: assert property (
      (b_to_a_latch_en && b_pin.drv) |=> a_out == $past(b_pin.data))
      else $error("b-to-a path not transparent");

   a_a_port_active_low: assert property (
      $fell(b_to_a_out_en_n) |-> a_oe == 18'h3ffff && $past(a_oe) == 18'h00000)
      else $error("port a enable polarity wrong");

   a_high_clock_keep: assert property (
      s_a2b_high_fall |-> $stable(b_out))
      else $error("held high clock disturbed stored value");

   a_port_a_role: assert property (
      (a_oe == 18'h3ffff && !b_to_a_latch_en && !$rose(b_to_a_clk))
         |=> a_out == $past(a_out))
      else $error("port a output changed without b-to-a load");

   a_bus_hold_keep: assert property (
      s_a_release |=> b_out == $past(a_pin.data, 2))
      else $error("bus hold lost the last driven level");

   a_contention_flag: assert property (
      (a_pin.drv && !b_to_a_out_en_n) |=> cont_a [*1])
      else $error("port a contention not flagged");

   a_paths_independent: assert property (
      (b_to_a_latch_en && !a_to_b_latch_en && !$rose(a_to_b_clk)) |=> $stable(b_out))
      else $error("b-to-a load disturbed a-to-b storage");

   a_apb_read_data: assert property (
      (apb_setup && !pwrite && hit_ctrl) |=> pready && prdata == {31'h00000000, hold_en})
      else $error("control read returned wrong data");

   a_apb_unmapped: assert property (
      (apb_setup && !mapped) |=> pslverr)
      else $error("unmapped address not refused");

   // b-to-a mirror of the a-to-b step sequences
   sequence s_b2a_rise;
      !b_to_a_clk ##1 (b_to_a_clk && !b_to_a_latch_en && b_pin.drv);
   endsequence

   sequence s_b2a_high_fall;
      (b_to_a_clk && b_to_a_latch_en) ##1 (b_to_a_clk && !b_to_a_latch_en) [*2];
   endsequence

   sequence s_b_release;
      (hold_en && b_pin.drv && b_to_a_latch_en)
         ##1 (hold_en && !b_pin.drv && b_to_a_latch_en);
   endsequence

   a_b2a_hold_steady: assert property (
      (!b_to_a_latch_en && !$rose(b_to_a_clk)) |=> $stable(a_out))
      else $error("b-to-a storage changed while latched");

   a_b2a_edge_capture: assert property (
      s_b2a_rise |=> a_out == $past(b_pin.data))
      else $error("b-to-a clock edge did not capture port b");

   a_b2a_high_keep: assert property (
      s_b2a_high_fall |-> $stable(a_out))
      else $error("held high b-to-a clock disturbed stored value");

   a_b2a_bus_hold: assert property (
      s_b_release |=> a_out == $past(b_pin.data, 2))
      else $error("bus hold on port b lost the last driven level");

   a_a2b_clock_ignored: assert property (
      (a_to_b_latch_en && $fell(a_to_b_clk) && a_pin.drv) |=> b_out == $past(a_pin.data))
      else $error("a-to-b clock disturbed transparent path");

   a_b_oe_float_now: assert property (
      $fell(a_to_b_out_en) |-> b_oe == 18'h00000)
      else $error("port b still driven after enable fell");

   a_a_port_drive: assert property (
      !b_to_a_out_en_n |-> a_oe == 18'h3ffff)
      else $error("port a not driven while enable low");

   a_a_port_float: assert property (
      b_to_a_out_en_n |-> a_oe == 18'h00000)
      else $error("port a driven while enable high");

   a_cont_b_flag: assert property (
      (b_pin.drv && a_to_b_out_en) |=> cont_b)
      else $error("port b contention not flagged");

   a_cont_a_clear: assert property (
      (cont_a && clr_cont_a && !set_cont_a) |=> !cont_a)
      else $error("port a contention flag not cleared");

   a_cont_b_clear: assert property (
      (cont_b && clr_cont_b && !set_cont_b) |=> !cont_b)
      else $error("port b contention flag not cleared");

   a_cont_a_sticky: assert property (
      (cont_a && !wr_status) |=> cont_a)
      else $error("port a contention flag lost");

   a_cont_b_sticky: assert property (
      (cont_b && !wr_status) |=> cont_b)
      else $error("port b contention flag lost");

   a_paths_indep_b: assert property (
      (a_to_b_latch_en && !b_to_a_latch_en && !$rose(b_to_a_clk)) |=> $stable(a_out))
      else $error("a-to-b load disturbed b-to-a storage");

   a_apb_ready_next: assert property (
      apb_setup |=> pready)
      else $error("access phase without ready");

   a_apb_idle_ready: assert property (
      !psel |-> !pready)
      else $error("ready outside a transfer");

   a_apb_err_access: assert property (
      !apb_access |-> !pslverr)
      else $error("error response outside access phase");

   a_apb_err_mapped: assert property (
      (apb_setup && mapped) |=> !pslverr)
      else $error("mapped address refused");

   a_apb_status_read: assert property (
      (apb_setup && !pwrite && hit_status) |=> prdata[1:0] == {$past(cont_b), $past(cont_a)})
      else $error("status read returned wrong flags");

   a_apb_status_upper: assert property (
      (apb_setup && !pwrite && hit_status) |=> prdata[31:8] == 24'h000000)
      else $error("status read upper bits not zero");

   a_apb_a2b_read: assert property (
      (apb_setup && !pwrite && hit_a2b) |=> prdata == {14'h0000, $past(b_out)})
      else $error("a-to-b storage read wrong");

   a_apb_b2a_read: assert property (
      (apb_setup && !pwrite && hit_b2a) |=> prdata == {14'h0000, $past(a_out)})
      else $error("b-to-a storage read wrong");

   a_apb_write_zero: assert property (
      (apb_setup && pwrite) |=> prdata == 32'h00000000)
      else $error("read data not cleared on write");

   a_apb_unmapped_zero: assert property (
      (apb_setup && !pwrite && !mapped) |=> prdata == 32'h00000000)
      else $error("unmapped read not zero");

   a_ctrl_write: assert property (
      (apb_access && pwrite && hit_ctrl && pstrb[0])
         |=> hold_en == $past(pwdata[`RBT_CTRL_HOLD_BIT]))
      else $error("control write did not land");

   a_ctrl_strobe_off: assert property (
      (apb_access && pwrite && !pstrb[0]) |=> $stable(hold_en))
      else $error("write without byte strobe changed control");

   a_ctrl_read_keep: assert property (
      (apb_access && !pwrite) |=> $stable(hold_en))
      else $error("read changed control");

   a_unmapped_ignored: assert property (
      (apb_access && pwrite && !mapped) |=> $stable(hold_en))
      else $error("unmapped write changed control");

   a_prdata_hold: assert property (
      !apb_setup |=> $stable(prdata))
      else $error("read data changed outside setup");

   a_store_upper_zero: assert property (
      (apb_setup && !pwrite && (hit_a2b || hit_b2a)) |=> prdata[31:18] == 14'h0000)
      else $error("storage read upper bits not zero");

endmodule : rbt_transceiver
`default_nettype wire

// ==== verif/rbt_far_logic.sv ====
`timescale 1ns/1ps
`default_nettype none
module rbt_far_logic (
   input wire logic pclk,
   input wire rbt_pkg::rbt_data_t a_val,
   input wire logic a_drv,
   input wire rbt_pkg::rbt_data_t b_val,
   input wire logic b_drv,
   input wire rbt_pkg::rbt_data_t a_out,
   input wire logic [17:0] a_oe,
   input wire rbt_pkg::rbt_data_t b_out,
   input wire logic [17:0] b_oe,
   output var rbt_pkg::rbt_pin_s a_pin,
   output var rbt_pkg::rbt_pin_s b_pin
);
   rbt_pkg::rbt_data_t a_last = 18'h00000;
   rbt_pkg::rbt_data_t b_last = 18'h00000;
   // a released line shows the inverse of its last driven level
   always_ff @(posedge pclk) begin
      if (a_drv) a_last <= a_val;
      if (b_drv) b_last <= b_val;
   end
   // drives only while the transceiver floats the port
   assign a_pin.drv = a_drv & ~|a_oe;
   assign b_pin.drv = b_drv & ~|b_oe;
   // wire level per bit from all drivers
   assign a_pin.data = (a_oe & a_out) | (~a_oe & (a_drv ? a_val : ~a_last));
   assign b_pin.data = (b_oe & b_out) | (~b_oe & (b_drv ? b_val : ~b_last));
endmodule : rbt_far_logic
`default_nettype wire

// ==== verif/registered_bus_transceiver_18bit_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rbt_regs.svh"
module registered_bus_transceiver_18bit_bench;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h00000000;
   logic [3:0] pstrb = 4'hf;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic a_to_b_out_en = 1'b0;
   logic a_to_b_latch_en = 1'b1;
   logic a_to_b_clk = 1'b0;
   logic b_to_a_out_en_n = 1'b1;
   logic b_to_a_latch_en = 1'b1;
   logic b_to_a_clk = 1'b0;
   rbt_pkg::rbt_data_t a_val = 18'h00000;
   rbt_pkg::rbt_data_t b_val = 18'h00000;
   logic a_drv = 1'b1;
   logic b_drv = 1'b0;
   rbt_pkg::rbt_pin_s a_pin;
   rbt_pkg::rbt_pin_s b_pin;
   rbt_pkg::rbt_data_t a_out;
   rbt_pkg::rbt_data_t b_out;
   logic [17:0] a_oe;
   logic [17:0] b_oe;
   logic [31:0] rd;
   logic err;
   int n_mismatch = 0;
   int total_checks = 0;

   rbt_transceiver DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .a_to_b_out_en, .a_to_b_latch_en, .a_to_b_clk,
      .b_to_a_out_en_n, .b_to_a_latch_en, .b_to_a_clk, .a_pin, .a_out, .a_oe, .b_pin,
      .b_out, .b_oe);
   rbt_far_logic far (.pclk, .a_val, .a_drv, .b_val, .b_drv, .a_out, .a_oe, .b_out, .b_oe,
      .a_pin, .b_pin);

   initial begin
      forever #2.5 pclk = ~pclk;
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask : tick

   // one apb transfer, started at a rising edge, result in rd and err
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
      int i;
      paddr <= addr;
      pwrite <= wr;
      pwdata <= wd;
      psel <= 1'b1;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 8; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 8) begin
         n_mismatch++;
         report_and_stop();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   initial begin
      tick(2);
      presetn <= 1'b1;
      b_to_a_latch_en <= 1'b0;
      tick(1);
      apb(1'b0, `RBT_OFS_CTRL, 32'h00000000);
      chk("ctrl", rd, 32'h00000000);
      apb(1'b0, 12'h010, 32'h00000000);
      chk("unmapped", {31'h00000000, err}, 32'h00000001);
      a_to_b_out_en <= 1'b1;
      a_to_b_latch_en <= 1'b1;
      a_val <= 18'h2a5c3;
      tick(2);
      chk("b transparent", 32'(b_out), 32'h0002a5c3);
      chk("b enabled", 32'(b_oe), 32'h0003ffff);
      a_to_b_clk <= 1'b1;
      a_val <= 18'h15a3c;
      tick(2);
      chk("b follows", 32'(b_out), 32'h00015a3c);
      a_to_b_latch_en <= 1'b0;
      a_val <= 18'h0f0f0;
      tick(3);
      chk("b held high clk", 32'(b_out), 32'h00015a3c);
      a_to_b_clk <= 1'b0;
      tick(2);
      chk("b held", 32'(b_out), 32'h00015a3c);
      a_to_b_clk <= 1'b1;
      tick(2);
      chk("b captured", 32'(b_out), 32'h0000f0f0);
      apb(1'b0, `RBT_OFS_A2B, 32'h00000000);
      chk("a2b reg", rd, 32'h0000f0f0);
      apb(1'b0, `RBT_OFS_STATUS, 32'h00000000);
      chk("status", rd, 32'h00000034);
      a_to_b_out_en <= 1'b0;
      a_drv <= 1'b0;
      b_drv <= 1'b1;
      b_val <= 18'h3c3c3;
      tick(2);
      chk("b floats", 32'(b_oe), 32'h00000000);
      chk("a floats", 32'(a_oe), 32'h00000000);
      b_to_a_out_en_n <= 1'b0;
      b_to_a_clk <= 1'b1;
      tick(2);
      chk("a captured", 32'(a_out), 32'h0003c3c3);
      chk("a enabled", 32'(a_oe), 32'h0003ffff);
      b_to_a_latch_en <= 1'b1;
      b_val <= 18'h01234;
      tick(2);
      b_drv <= 1'b0;
      tick(3);
      chk("no hold", 32'(a_out), 32'h0003edcb);
      apb(1'b1, `RBT_OFS_CTRL, 32'h00000001);
      apb(1'b0, `RBT_OFS_CTRL, 32'h00000000);
      chk("ctrl set", rd, 32'h00000001);
      tick(2);
      chk("bus hold", 32'(a_out), 32'h00001234);
      b_to_a_out_en_n <= 1'b1;
      a_to_b_latch_en <= 1'b1;
      a_val <= 18'h12345;
      a_drv <= 1'b1;
      tick(2);
      a_drv <= 1'b0;
      tick(3);
      chk("b bus hold", 32'(b_out), 32'h00012345);
      report_and_stop();
   end
endmodule : registered_bus_transceiver_18bit_bench
`default_nettype wire
